// ---- design/flash_reset_pkg.sv ----
package flash_reset_pkg;

  // ----------------------------------------
  // Clock
  // ----------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 40;

  // ----------------------------------------
  // Documented times
  // ----------------------------------------
  localparam int unsigned RESET_MIN_LOW_TIME_NS = 100;
  localparam int unsigned RESET_ABORT_TIME_US = 25;
  localparam int unsigned POWER_VALID_TO_RELEASE_TIME_OLD_US = 90;
  localparam int unsigned POWER_VALID_TO_RELEASE_TIME_NEW_US = 300;
  localparam int unsigned ERASE_TO_SUSPEND_SPACING_US = 500;

  // Least time rounds up, longest time rounds down
  localparam int unsigned RESET_MIN_LOW_CYC =
    (RESET_MIN_LOW_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned RESET_ABORT_CYC = (RESET_ABORT_TIME_US * 1000) / CLK_PERIOD_NS;
  localparam int unsigned POWER_VALID_OLD_CYC =
    (POWER_VALID_TO_RELEASE_TIME_OLD_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned POWER_VALID_NEW_CYC =
    (POWER_VALID_TO_RELEASE_TIME_NEW_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned ERASE_SUSPEND_CYC = (ERASE_TO_SUSPEND_SPACING_US * 1000) / CLK_PERIOD_NS;

  // Abort completes on a shorter internal timebase than its ceiling
  localparam int unsigned ABORT_DONE_CYC = 64;

  // ----------------------------------------
  // Widths and reset values
  // ----------------------------------------
  localparam int unsigned CNT_W = 16;
  localparam logic [7:0] STATUS_RESET_VAL = 8'h80;

  typedef enum logic [1:0] {
    OP_IDLE,
    OP_PROGRAM,
    OP_ERASE
  } op_kind_t;

  typedef struct packed {
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic adv_n;
  } bus_ctrl_t;

  typedef struct packed {
    logic program_start;
    logic erase_start;
    logic erase_resume;
    logic erase_suspend;
    logic op_done;
  } op_cmd_t;

endpackage

// ---- design/interval_timer.sv ----
`timescale 1ns/1ps
module interval_timer (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  input wire logic clk_en_i,
  // Control
  input wire logic start_i,
  input wire logic [flash_reset_pkg::CNT_W-1:0] load_i,
  // Status
  output logic busy_o,
  output logic done_o
);
  import flash_reset_pkg::*;

  logic [CNT_W-1:0] count_r;

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      count_r <= '0;
    end else if (clk_en_i) begin
      if (start_i) begin
        count_r <= load_i;
      end else if (count_r != '0) begin
        count_r <= count_r - 1'b1;
      end
    end
  end

  assign busy_o = (count_r != '0);
  assign done_o = (count_r == {{(CNT_W-1){1'b0}}, 1'b1}) && clk_en_i && !start_i;
endmodule

// ---- design/flash_reset_sequencer.sv ----
`timescale 1ns/1ps
// Summary of operation
// - Reset during erase aborts it and settles within 25 us.
// - Reset during program aborts it and settles within 25 us.
// - Reset with no operation running finishes within minimum low time.
// - All control inputs ignored while reset is low.
// - With reset tied high, stay not-ready for power-valid interval.
// - After reset release enter array-read mode, status becomes 0x80.
// - Data and wait outputs undriven while reset is held.
// - Aborted operation marks its word or block content undefined.
module flash_reset_sequencer (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  input wire logic clk_en_i,
  // Pins from host
  input wire logic rst_pin_n_i,
  input wire logic power_valid_i,
  input wire logic new_process_i,
  input wire flash_reset_pkg::bus_ctrl_t bus_ctrl_i,
  // Internal command decode and engine
  input wire flash_reset_pkg::op_cmd_t op_cmd_i,
  input wire logic [15:0] read_data_i,
  input wire logic wait_i,
  // Pin outputs
  output logic [15:0] dq_o,
  output logic dq_oe_o,
  output logic wait_o,
  output logic wait_oe_o,
  // Status
  output logic ready_o,
  output logic array_read_mode_o,
  output logic [7:0] status_o,
  output logic op_abort_o,
  output logic content_undefined_o,
  output flash_reset_pkg::op_kind_t aborted_kind_o,
  output logic early_suspend_o,
  output logic erase_at_risk_o
);
  import flash_reset_pkg::*;

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic rst_meta_r, rst_sync_r, pwr_meta_r, pwr_sync_r;
  bus_ctrl_t ctrl_meta_r, ctrl_sync_r;

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
      pwr_meta_r <= 1'b0;
      pwr_sync_r <= 1'b0;
      ctrl_meta_r <= '1;
      ctrl_sync_r <= '1;
    end else if (clk_en_i) begin
      rst_meta_r <= rst_pin_n_i;
      rst_sync_r <= rst_meta_r;
      pwr_meta_r <= power_valid_i;
      pwr_sync_r <= pwr_meta_r;
      ctrl_meta_r <= bus_ctrl_i;
      ctrl_sync_r <= ctrl_meta_r;
    end
  end

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  typedef enum logic [2:0] {
    ST_POWER_WAIT,
    ST_HELD,
    ST_ABORTING,
    ST_RESET_DONE,
    ST_ACTIVE
  } seq_state_t;

  seq_state_t state_r, state_nxt;
  op_kind_t op_r;
  logic tmr_start, tmr_busy, tmr_done;
  logic [CNT_W-1:0] tmr_load;
  logic pwr_seen_r;

  // Intervals measured on the shared timer
  interval_timer u_timer (
    .core_clk_i(core_clk_i),
    .reset_n_i(reset_n_i),
    .clk_en_i(clk_en_i),
    .start_i(tmr_start),
    .load_i(tmr_load),
    .busy_o(tmr_busy),
    .done_o(tmr_done)
  );

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pwr_seen_r <= 1'b0;
    end else if (clk_en_i) begin
      pwr_seen_r <= pwr_sync_r;
    end
  end

  always_comb begin
    state_nxt = state_r;
    tmr_start = 1'b0;
    tmr_load = '0;
    case (state_r)
      ST_POWER_WAIT: begin
        // Not ready until the power-valid interval elapses, even if reset is tied high
        if (pwr_sync_r && !pwr_seen_r) begin
          tmr_start = 1'b1;
          tmr_load = new_process_i ? CNT_W'(POWER_VALID_NEW_CYC) : CNT_W'(POWER_VALID_OLD_CYC);
        end else if (pwr_seen_r && !tmr_busy) begin
          state_nxt = rst_sync_r ? ST_ACTIVE : ST_HELD;
        end
      end
      ST_ACTIVE: begin
        if (!rst_sync_r) begin
          tmr_start = 1'b1;
          if (op_r != OP_IDLE) begin
            tmr_load = CNT_W'(ABORT_DONE_CYC);
            state_nxt = ST_ABORTING;
          end else begin
            tmr_load = CNT_W'(RESET_MIN_LOW_CYC);
            state_nxt = ST_ABORTING;
          end
        end
      end
      ST_ABORTING: begin
        if (tmr_done || !tmr_busy) begin
          state_nxt = ST_RESET_DONE;
        end
      end
      ST_RESET_DONE: begin
        if (rst_sync_r) begin
          state_nxt = ST_ACTIVE;
        end
      end
      ST_HELD: begin
        if (rst_sync_r) begin
          state_nxt = ST_ACTIVE;
        end
      end
      default: state_nxt = ST_POWER_WAIT;
    endcase
    if (!pwr_sync_r) begin
      state_nxt = ST_POWER_WAIT;
    end
  end

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_r <= ST_POWER_WAIT;
    end else if (clk_en_i) begin
      state_r <= state_nxt;
    end
  end

  // ----------------------------------------
  // Operation tracking
  // ----------------------------------------
  logic ctrl_live;
  // Commands only count when reset is high and the device is settled
  assign ctrl_live = rst_sync_r && (state_r == ST_ACTIVE);

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      op_r <= OP_IDLE;
    end else if (clk_en_i) begin
      if (!ctrl_live) begin
        op_r <= OP_IDLE;
      end else if (op_cmd_i.op_done) begin
        op_r <= OP_IDLE;
      end else if (op_cmd_i.erase_start || op_cmd_i.erase_resume) begin
        op_r <= OP_ERASE;
      end else if (op_cmd_i.program_start) begin
        op_r <= OP_PROGRAM;
      end
    end
  end

  // Abort marks content undefined until the next operation starts
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      content_undefined_o <= 1'b0;
      aborted_kind_o <= OP_IDLE;
    end else if (clk_en_i) begin
      if (state_r == ST_ACTIVE && !rst_sync_r && op_r != OP_IDLE) begin
        content_undefined_o <= 1'b1;
        aborted_kind_o <= op_r;
      end else if (ctrl_live && (op_cmd_i.program_start || op_cmd_i.erase_start)) begin
        content_undefined_o <= 1'b0;
        aborted_kind_o <= OP_IDLE;
      end
    end
  end

  // ----------------------------------------
  // Erase-to-suspend spacing monitor
  // ----------------------------------------
  // Only flagged: the host owns the spacing, the device must still obey
  logic [CNT_W-1:0] susp_cnt_r;
  logic [1:0] early_cnt_r;

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      susp_cnt_r <= '0;
      early_cnt_r <= '0;
      early_suspend_o <= 1'b0;
    end else if (clk_en_i) begin
      early_suspend_o <= 1'b0;
      if (!ctrl_live || op_cmd_i.erase_start) begin
        early_cnt_r <= '0;
      end
      if (ctrl_live && (op_cmd_i.erase_start || op_cmd_i.erase_resume)) begin
        susp_cnt_r <= CNT_W'(ERASE_SUSPEND_CYC);
      end else if (susp_cnt_r != '0) begin
        susp_cnt_r <= susp_cnt_r - 1'b1;
      end
      if (ctrl_live && op_cmd_i.erase_suspend && susp_cnt_r != '0) begin
        early_suspend_o <= 1'b1;
        if (early_cnt_r != 2'h3) begin
          early_cnt_r <= early_cnt_r + 2'h1;
        end
      end
    end
  end
  assign erase_at_risk_o = (early_cnt_r >= 2'h2);

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  logic read_en;
  assign read_en = ctrl_live && !ctrl_sync_r.ce_n && !ctrl_sync_r.oe_n && ctrl_sync_r.we_n;

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      dq_o <= '0;
      dq_oe_o <= 1'b0;
      wait_o <= 1'b0;
      wait_oe_o <= 1'b0;
      status_o <= STATUS_RESET_VAL;
      array_read_mode_o <= 1'b1;
    end else if (clk_en_i) begin
      dq_oe_o <= read_en;
      wait_oe_o <= read_en;
      dq_o <= read_en ? read_data_i : 16'h0000;
      wait_o <= read_en ? wait_i : 1'b0;
      if (state_r != ST_ACTIVE) begin
        status_o <= STATUS_RESET_VAL;
        array_read_mode_o <= 1'b1;
      end else if (op_r != OP_IDLE) begin
        status_o <= 8'h00;
        array_read_mode_o <= 1'b0;
      end else begin
        status_o <= STATUS_RESET_VAL;
      end
    end
  end

  assign ready_o = (state_r == ST_ACTIVE);
  assign op_abort_o = (state_r == ST_ABORTING);

endmodule

// ---- verification/flash_reset_sequencer_asserts.sv ----
`timescale 1ns/1ps
module flash_reset_sequencer_asserts (
  // Clock and pins
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  input wire logic rst_pin_n_i,
  input wire logic power_valid_i,
  input wire logic new_process_i,
  input wire flash_reset_pkg::op_cmd_t op_cmd_i,
  // Outputs
  input wire logic dq_oe_o,
  input wire logic wait_oe_o,
  input wire logic ready_o,
  input wire logic array_read_mode_o,
  input wire logic [7:0] status_o,
  input wire logic op_abort_o,
  input wire logic content_undefined_o,
  input wire logic early_suspend_o
);
  logic [13:0] pw_cnt_r;

  // Cycles since supply valid, saturating
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i)
      pw_cnt_r <= 14'h0000;
    else if (!power_valid_i)
      pw_cnt_r <= 14'h0000;
    else if (pw_cnt_r != 14'h3fff)
      pw_cnt_r <= pw_cnt_r + 14'h0001;
  end

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!reset_n_i);

  property p_pin_masks;
    !rst_pin_n_i [*6] |-> !ready_o;
  endproperty
  a_pin_masks: assert property (p_pin_masks) else $error("ready with pin low");

  property p_pins_released;
    !rst_pin_n_i [*6] |-> !dq_oe_o && !wait_oe_o;
  endproperty
  a_pins_released: assert property (p_pins_released) else $error("pins driven in reset");

  property p_idle_reset;
    $rose(op_abort_o) && $past(status_o) == 8'h80 |-> ##[1:4] !op_abort_o;
  endproperty
  a_idle_reset: assert property (p_idle_reset) else $error("idle reset too long");

  property p_abort_bound;
    $rose(op_abort_o) |-> ##[1:625] !op_abort_o;
  endproperty
  a_abort_bound: assert property (p_abort_bound) else $error("abort too long");

  property p_release_state;
    $rose(ready_o) |-> status_o == 8'h80 && array_read_mode_o;
  endproperty
  a_release_state: assert property (p_release_state) else $error("bad state on release");

  property p_abort_marks;
    $rose(op_abort_o) && $past(status_o) == 8'h00 |-> ##[0:80] content_undefined_o;
  endproperty
  a_abort_marks: assert property (p_abort_marks) else $error("abort not marked");

  property p_power_wait;
    ready_o |-> pw_cnt_r >= (new_process_i ? 14'h1d4c : 14'h08ca);
  endproperty
  a_power_wait: assert property (p_power_wait) else $error("ready too early");

  property p_early;
    (ready_o && op_cmd_i.erase_start) ##2 (ready_o && op_cmd_i.erase_suspend) |-> ##[0:2] early_suspend_o;
  endproperty
  a_early: assert property (p_early) else $error("early suspend missed");
endmodule

bind flash_reset_sequencer flash_reset_sequencer_asserts u_chk (
  .core_clk_i, .reset_n_i, .rst_pin_n_i, .power_valid_i, .new_process_i, .op_cmd_i,
  .dq_oe_o, .wait_oe_o, .ready_o, .array_read_mode_o, .status_o, .op_abort_o,
  .content_undefined_o, .early_suspend_o
);

// ---- verification/flash_host_model.sv ----
`timescale 1ns/1ps
module flash_host_model (
  // Clock
  input wire logic core_clk_i,
  // Pins to device
  output logic rst_pin_n_o,
  output logic power_valid_o,
  output flash_reset_pkg::bus_ctrl_t bus_ctrl_o,
  output flash_reset_pkg::op_cmd_t op_cmd_o
);
  import flash_reset_pkg::*;

  initial begin
    rst_pin_n_o = 1'b1;
    power_valid_o = 1'b0;
    bus_ctrl_o = '1;
    op_cmd_o = '0;
  end

  // Bus noise all the time
  always @(posedge core_clk_i) begin
    bus_ctrl_o <= 4'($urandom);
  end

  task automatic power_on();
    @(posedge core_clk_i);
    power_valid_o <= 1'b1;
  endtask

  task automatic cmd(input logic [4:0] c);
    @(posedge core_clk_i);
    op_cmd_o <= c;
    @(posedge core_clk_i);
    op_cmd_o <= '0;
  endtask

  // Short pulses are never trusted, so never sent
  task automatic pin_reset(input int lo);
    @(posedge core_clk_i);
    rst_pin_n_o <= 1'b0;
    // Noise starts only once the pin has crossed the synchroniser
    for (int k = 0; k < (lo < RESET_MIN_LOW_CYC ? RESET_MIN_LOW_CYC : lo); k++) begin
      @(posedge core_clk_i);
      op_cmd_o <= (k < 2) ? 5'h00 : 5'($urandom);
    end
    @(posedge core_clk_i);
    op_cmd_o <= '0;
    rst_pin_n_o <= 1'b1;
  endtask

  // Supply only moves while the pin holds the device in reset
  task automatic power_down();
    @(posedge core_clk_i);
    rst_pin_n_o <= 1'b0;
    repeat (8) @(posedge core_clk_i);
    power_valid_o <= 1'b0;
    repeat (4) @(posedge core_clk_i);
  endtask

  task automatic power_up_held(input logic np);
    @(posedge core_clk_i);
    power_valid_o <= 1'b1;
    repeat ((np ? POWER_VALID_NEW_CYC : POWER_VALID_OLD_CYC) + 4) @(posedge core_clk_i);
    rst_pin_n_o <= 1'b1;
  endtask
endmodule

// ---- verification/flash_reset_sequencer_test.sv ----
`timescale 1ns/1ps
module flash_reset_sequencer_test;
  import flash_reset_pkg::*;
  logic core_clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic [15:0] read_data_i;
  logic wait_i;
  logic clk_en = 1'b1;
  logic new_process = 1'b0;
  logic [15:0] rd_q;
  logic wt_q, en_q;
  logic rst_pin_n_i, power_valid_i, ready_o, array_read_mode_o, op_abort_o, dq_oe_o, wait_o;
  logic wait_oe_o, content_undefined_o, early_suspend_o, erase_at_risk_o;
  logic [15:0] dq_o;
  logic [7:0] status_o;
  bus_ctrl_t bus_ctrl_i;
  op_cmd_t op_cmd_i;
  op_kind_t aborted_kind_o;
  op_kind_t kinds[$] = '{OP_IDLE, OP_PROGRAM, OP_IDLE, OP_ERASE};
  int bad_count = 0;
  int total_checks = 0;
  int abort_len = 0;
  int early_cnt = 0;
  int n;
  int pw_exp;
  logic undef_m = 1'b0;

  flash_reset_sequencer dut (
    .core_clk_i, .reset_n_i, .clk_en_i(clk_en), .rst_pin_n_i, .power_valid_i, .new_process_i(new_process),
    .bus_ctrl_i, .op_cmd_i, .read_data_i, .wait_i, .dq_o, .dq_oe_o, .wait_o, .wait_oe_o, .ready_o,
    .array_read_mode_o, .status_o, .op_abort_o, .content_undefined_o, .aborted_kind_o,
    .early_suspend_o, .erase_at_risk_o
  );

  flash_host_model u_host (
    .core_clk_i, .rst_pin_n_o(rst_pin_n_i), .power_valid_o(power_valid_i),
    .bus_ctrl_o(bus_ctrl_i), .op_cmd_o(op_cmd_i)
  );

  initial begin
    forever #20 core_clk_i = ~core_clk_i;
  end

  always @(posedge core_clk_i) begin
    read_data_i <= 16'($urandom);
    wait_i <= 1'($urandom);
    if (op_abort_o === 1'b1) abort_len <= abort_len + 1;
    if (early_suspend_o === 1'b1) early_cnt <= early_cnt + 1;
    rd_q <= read_data_i;
    wt_q <= wait_i;
    en_q <= clk_en;
    // Driven pins carry what was offered on the enabled edge before
    if (en_q === 1'b1 && dq_oe_o === 1'b1) begin
      chk(dq_o, rd_q);
      chk(16'({wait_oe_o, wait_o}), 16'({1'b1, wt_q}));
    end
  end

  task automatic close_out();
    if (bad_count == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wait_ready(input int lim);
    n = 0;
    while (ready_o !== 1'b1) begin
      @(posedge core_clk_i);
      #1;
      n++;
      if (n > lim) begin
        bad_count++;
        close_out();
      end
    end
  endtask

  initial begin
    void'($urandom(87491));
    repeat (2) @(posedge core_clk_i);
    reset_n_i <= 1'b1;
    new_process <= 1'($urandom);
    u_host.power_on();
    wait_ready(8000);
    pw_exp = new_process ? POWER_VALID_NEW_CYC : POWER_VALID_OLD_CYC;
    chk(16'(n >= pw_exp && n <= pw_exp + 8), 16'h0001);
    // Frozen clock enable: a command must not be taken
    @(posedge core_clk_i);
    clk_en <= 1'b0;
    u_host.cmd(5'b10000);
    repeat (3) @(posedge core_clk_i);
    #1;
    chk(16'({ready_o, status_o}), 16'h0180);
    @(posedge core_clk_i);
    clk_en <= 1'b1;
    foreach (kinds[i]) begin
      if (kinds[i] != OP_IDLE) begin
        u_host.cmd(kinds[i] == OP_ERASE ? 5'b01000 : 5'b10000);
        undef_m = 1'b0;
      end
      repeat (3) @(posedge core_clk_i);
      #1;
      chk(16'(status_o), kinds[i] == OP_IDLE ? 16'h0080 : 16'h0000);
      abort_len = 0;
      u_host.pin_reset(90 + $urandom_range(20));
      wait_ready(20);
      n = (kinds[i] == OP_IDLE) ? RESET_MIN_LOW_CYC : RESET_ABORT_CYC;
      chk(16'(abort_len > 0 && abort_len <= n), 16'h0001);
      chk(16'({status_o, array_read_mode_o}), 16'h0101);
      if (kinds[i] != OP_IDLE) begin
        undef_m = 1'b1;
        chk(16'(aborted_kind_o), 16'(kinds[i]));
      end
      chk(16'(content_undefined_o), 16'(undef_m));
    end
    // Suspends far too soon after start and after resume
    u_host.cmd(5'b01000);
    u_host.cmd(5'b00010);
    repeat (3) @(posedge core_clk_i);
    #1;
    chk(16'({early_cnt[1:0], erase_at_risk_o}), 16'h0002);
    u_host.cmd(5'b00100);
    u_host.cmd(5'b00010);
    repeat (3) @(posedge core_clk_i);
    #1;
    chk(16'({early_cnt[1:0], erase_at_risk_o}), 16'h0005);
    u_host.cmd(5'b00001);
    // Power cycle under a held pin, other process version
    u_host.power_down();
    @(posedge core_clk_i);
    new_process <= ~new_process;
    #1;
    u_host.power_up_held(new_process);
    wait_ready(20);
    chk(16'({status_o, array_read_mode_o}), 16'h0101);
    close_out();
  end
endmodule
